// ### ppm_pkg.sv
package ppm_pkg;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0]  CTRL_IDX      = 8'h00;
    localparam logic [7:0]  STAT_IDX      = 8'h01;
    localparam logic [7:0]  MODE_IDX      = 8'h11;
    localparam logic [7:0]  EXT2_IDX      = 8'h13;

    // ==========================================================
    // Field positions
    localparam int          CTRL_SWRST    = 15;
    localparam int          CTRL_SPEED    = 13;
    localparam int          CTRL_AN_EN    = 12;
    localparam int          CTRL_PD       = 11;
    localparam int          CTRL_DUPLEX   = 8;
    localparam int          STAT_LINK_LL  = 2;
    localparam int          STAT_RF_LH    = 4;
    localparam int          STAT_PEAK_LO  = 8;
    localparam int          EXT2_APS100   = 0;
    localparam int          EXT2_APS10    = 1;
    localparam int          EXT2_XO_LO    = 8;

    // ==========================================================
    // Reset values
    localparam logic [15:0] CTRL_RST      = 16'h3000;
    localparam logic [15:0] EXT2_RST      = 16'h0000;
    localparam logic [1:0]  XO_AUTO       = 2'b00;
    localparam logic [1:0]  XO_FORCE_MDIX = 2'b10;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          XO_WAIT_NS    = 20000;
    localparam int          XO_WAIT_CYC   = XO_WAIT_NS * 1000 / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        NEG_IDLE  = 2'b00,
        NEG_XOVER = 2'b01,
        NEG_EXCH  = 2'b10,
        NEG_DONE  = 2'b11
    } ppm_neg_t;

    typedef struct packed {
        logic speed100;
        logic full_duplex;
    } ppm_mode_t;

    typedef struct packed {
        logic [3:0] rxd;
        logic       rx_dv;
        logic       rx_er;
    } ppm_rx_t;

endpackage : ppm_pkg

// ### ppm_phy_mode_ctrl.sv
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module ppm_phy_mode_ctrl
    import ppm_pkg::*;
#(
    parameter int XO_WAIT_CYCLES = XO_WAIT_CYC
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        hw_reset_pin_active_low,
    input  wire logic        config_source_select_pin,
    input  wire logic        negotiation_select_pin,
    input  wire logic        speed_select_pin,
    input  wire logic        duplex_select_pin,
    input  wire logic        crossover_enable_pin,
    input  wire logic        link_up,
    input  wire logic        partner_valid,
    input  wire logic [3:0]  partner_ability,
    input  wire logic        remote_fault,
    input  wire logic [3:0]  noise_level,
    input  wire logic        rx_activity,
    input  wire logic        tx_activity,
    input  wire ppm_rx_t     rx_in,
    input  wire logic        tx_pos_data,
    input  wire logic        tx_neg_data,
    output ppm_rx_t          rx_out,
    output logic             crs,
    output logic             col,
    output logic             pair_tx_positive,
    output logic             pair_tx_positive_oe_n,
    output logic             pair_tx_negative,
    output logic             pair_tx_negative_oe_n,
    output logic             pair_swap,
    output logic             pcs100_enable,
    output logic             pcs10_enable,
    output logic             loopback_enable,
    output logic             sqe_test_enable,
    output ppm_mode_t        op_mode
);

    if (XO_WAIT_CYCLES < 2 || XO_WAIT_CYCLES > 65535) begin : g_bad_wait
        $error("XO_WAIT_CYCLES out of range");
    end

    // ==========================================================
    // Bus slave
    logic [15:0] ctrl;
    logic [15:0] ext2;
    logic        link_ll;
    logic        rf_lh;
    logic [3:0]  peak;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    ppm_neg_t    neg;
    logic        mdix;

    wire         acc     = hsel & htrans[1] & hready;
    wire  [7:0]  a_idx   = haddr[9:2];
    wire         rd_acc  = acc & ~hwrite;
    wire         rd_stat = rd_acc & (a_idx == STAT_IDX);
    wire         wr_ctrl = wr_pend & (wr_idx == CTRL_IDX);
    wire         wr_ext2 = wr_pend & (wr_idx == EXT2_IDX);
    wire         hw_rst  = ~hw_reset_pin_active_low;
    wire         sw_rst  = wr_ctrl & hwdata[CTRL_SWRST];
    wire         pd      = hw_rst | ctrl[CTRL_PD];
    wire  [15:0] stat_v  = {4'h0, peak, 3'h0, rf_lh, 1'b0, link_ll, 2'b00};
    wire  [15:0] mode_v  = {9'h000, pd, neg, 1'b0, mdix, op_mode};
    wire  [15:0] rd_v    = (a_idx == CTRL_IDX) ? ctrl :
                           (a_idx == STAT_IDX) ? stat_v :
                           (a_idx == MODE_IDX) ? mode_v :
                           (a_idx == EXT2_IDX) ? ext2 : 16'h0000;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_idx  <= 8'h00;
            hrdata  <= 32'h0000_0000;
        end else begin
            wr_pend <= acc & hwrite;
            wr_idx  <= a_idx;
            hrdata  <= rd_acc ? {16'h0000, rd_v} : 32'h0000_0000;
        end
    end

    // Hardware or software reset returns ctrl and ext2 to their defaults
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RST;
            ext2 <= EXT2_RST;
        end else if (hw_rst || sw_rst) begin
            ctrl <= CTRL_RST;
            ext2 <= EXT2_RST;
        end else begin
            if (wr_ctrl)
                ctrl <= hwdata[15:0] & 16'h3900;
            if (wr_ext2)
                ext2 <= hwdata[15:0] & 16'h0303;
        end
    end

    // ==========================================================
    // Latched status; an event in the read cycle wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_ll <= 1'b0;
            rf_lh   <= 1'b0;
            peak    <= 4'h0;
        end else if (pd || sw_rst) begin
            link_ll <= 1'b0;
            rf_lh   <= 1'b0;
            peak    <= 4'h0;
        end else begin
            if (!link_up)
                link_ll <= 1'b0;
            else if (rd_stat)
                link_ll <= 1'b1;
            if (remote_fault)
                rf_lh <= 1'b1;
            else if (rd_stat)
                rf_lh <= 1'b0;
            if (rd_stat)
                peak <= noise_level;
            else if (noise_level > peak)
                peak <= noise_level;
        end
    end

    // ==========================================================
    // Configuration source
    wire an_enable = config_source_select_pin ? ctrl[CTRL_AN_EN]
                                              : negotiation_select_pin;
    wire cfg_speed = config_source_select_pin ? ctrl[CTRL_SPEED] : speed_select_pin;
    wire cfg_fd    = config_source_select_pin ? ctrl[CTRL_DUPLEX] : duplex_select_pin;
    wire xo_auto   = crossover_enable_pin &
                     (ext2[EXT2_XO_LO+1:EXT2_XO_LO] == XO_AUTO);

    // Best mode the partner advertises; ability bits are 100FD,100HD,10FD,10HD
    function automatic ppm_mode_t best_mode(input logic [3:0] ab);
        ppm_mode_t m;
        m = '{speed100: 1'b0, full_duplex: 1'b0};
        if (ab[3])
            m = '{speed100: 1'b1, full_duplex: 1'b1};
        else if (ab[2])
            m = '{speed100: 1'b1, full_duplex: 1'b0};
        else if (ab[1])
            m = '{speed100: 1'b0, full_duplex: 1'b1};
        return m;
    endfunction : best_mode

    // ==========================================================
    // Crossover: swaps on a timer while no link, regardless of negotiation
    logic [15:0] xo_cnt;
    wire         xo_hit = (xo_cnt == 16'(XO_WAIT_CYCLES - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xo_cnt <= 16'h0000;
            mdix   <= 1'b0;
        end else if (pd) begin
            xo_cnt <= 16'h0000;
            mdix   <= 1'b0;
        end else if (!xo_auto) begin
            xo_cnt <= 16'h0000;
            mdix   <= (ext2[EXT2_XO_LO+1:EXT2_XO_LO] == XO_FORCE_MDIX);
        end else if (link_up) begin
            xo_cnt <= 16'h0000;
        end else begin
            xo_cnt <= xo_hit ? 16'h0000 : xo_cnt + 16'h0001;
            if (xo_hit)
                mdix <= ~mdix;
        end
    end

    // ==========================================================
    // Negotiation waits for a link, so the pair choice is settled first
    ppm_neg_t  next_neg;
    ppm_mode_t neg_mode;

    always_comb begin
        next_neg = neg;
        case (neg)
            NEG_IDLE:  next_neg = an_enable ? NEG_XOVER : NEG_IDLE;
            NEG_XOVER: next_neg = link_up ? NEG_EXCH : NEG_XOVER;
            NEG_EXCH:  next_neg = partner_valid ? NEG_DONE : NEG_EXCH;
            NEG_DONE:  next_neg = (an_enable && !link_up) ? NEG_XOVER : NEG_DONE;
            default:   next_neg = NEG_IDLE;
        endcase
        if (!an_enable)
            next_neg = NEG_IDLE;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            neg      <= NEG_IDLE;
            neg_mode <= '{speed100: 1'b0, full_duplex: 1'b0};
        end else if (pd) begin
            neg      <= NEG_IDLE;
            neg_mode <= '{speed100: 1'b0, full_duplex: 1'b0};
        end else begin
            neg <= next_neg;
            if (neg == NEG_EXCH && partner_valid)
                neg_mode <= best_mode(partner_ability);
        end
    end

    wire ppm_mode_t mode_v2 = an_enable ? neg_mode : '{speed100: cfg_speed,
                                                       full_duplex: cfg_fd};
    wire fd   = mode_v2.full_duplex;
    wire crs_v = rx_activity | (~fd & tx_activity);
    wire col_v = ~fd & rx_activity & tx_activity;

    // ==========================================================
    // Host and line outputs, all but op_mode quiet while powered down
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_out                <= '0;
            crs                   <= 1'b0;
            col                   <= 1'b0;
            pair_tx_positive      <= 1'b0;
            pair_tx_negative      <= 1'b0;
            pair_tx_positive_oe_n <= 1'b1;
            pair_tx_negative_oe_n <= 1'b1;
            pair_swap             <= 1'b0;
            pcs100_enable         <= 1'b0;
            pcs10_enable          <= 1'b0;
            loopback_enable       <= 1'b0;
            sqe_test_enable       <= 1'b0;
            op_mode               <= '0;
        end else begin
            rx_out                <= pd ? '0 : rx_in;
            crs                   <= ~pd & crs_v;
            col                   <= ~pd & col_v;
            pair_tx_positive      <= ~pd & tx_pos_data;
            pair_tx_negative      <= ~pd & tx_neg_data;
            pair_tx_positive_oe_n <= pd;
            pair_tx_negative_oe_n <= pd;
            pair_swap             <= mdix;
            pcs100_enable         <= ~pd & (mode_v2.speed100 | ~ext2[EXT2_APS100]);
            pcs10_enable          <= ~pd & (~mode_v2.speed100 | ~ext2[EXT2_APS10]);
            loopback_enable       <= ~pd & ~mode_v2.speed100 & ~fd;
            sqe_test_enable       <= ~pd & ~mode_v2.speed100 & ~fd;
            op_mode               <= mode_v2;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_pd_quiet;
        pd |=> !crs && !col && rx_out == '0 && !pcs100_enable && !pcs10_enable;
    endproperty
    a_pd_quiet: assert property (p_pd_quiet) else $error("host outputs not quiet");

    property p_tx_hiz;
        pd |=> pair_tx_positive_oe_n && pair_tx_negative_oe_n;
    endproperty
    a_tx_hiz: assert property (p_tx_hiz) else $error("tx pins driven in pd");

    property p_latch_clr;
        $rose(ctrl[CTRL_PD]) |=> stat_v == 16'h0000;
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latched bits kept");

    property p_keep_ext2;
        ctrl[CTRL_PD] && !hw_rst && !wr_pend |=> $stable(ext2) && $stable(ctrl);
    endproperty
    a_keep_ext2: assert property (p_keep_ext2) else $error("registers lost");

    property p_hw_defaults;
        hw_rst |=> ctrl == CTRL_RST && ext2 == EXT2_RST &&
                   ext2[EXT2_XO_LO+1:EXT2_XO_LO] == XO_AUTO;
    endproperty
    a_hw_defaults: assert property (p_hw_defaults) else $error("reset defaults");

    property p_aps;
        !pd && !mode_v2.speed100 |=> pcs100_enable == !$past(ext2[EXT2_APS100]) && pcs10_enable;
    endproperty
    a_aps: assert property (p_aps) else $error("100M power save");

    property p_aps10;
        !pd && mode_v2.speed100 |=> pcs10_enable == !$past(ext2[EXT2_APS10]) && pcs100_enable;
    endproperty
    a_aps10: assert property (p_aps10) else $error("10M power save");

    property p_an_src;
        !config_source_select_pin |-> an_enable == negotiation_select_pin;
    endproperty
    a_an_src: assert property (p_an_src) else $error("negotiation source");

    property p_fd_col;
        !pd && fd |=> !col ##0 (crs == $past(rx_activity));
    endproperty
    a_fd_col: assert property (p_fd_col) else $error("full duplex carrier");

    property p_swap;
        !pd && xo_auto && !link_up && xo_hit |=> mdix != $past(mdix) ##1 pair_swap == $past(mdix);
    endproperty
    a_swap: assert property (p_swap) else $error("crossover swap missed");

endmodule : ppm_phy_mode_ctrl

// ### ppm_link_partner.sv
`timescale 1ns/1ps
module ppm_link_partner #(
    parameter int LINK_DLY = 3
)(
    input  wire logic       hclk,
    input  wire logic       plugged,
    input  wire logic       crossed,
    input  wire logic       tx_oe_n,
    input  wire logic       swap,
    input  wire logic [3:0] ability,
    output logic            link_up,
    output logic            partner_valid,
    output logic [3:0]      partner_ability
);
    // ==========================================================
    // Link training: energy arrives only on the right pair order
    int        cnt = 0;
    wire logic energy = plugged && !tx_oe_n && (swap == crossed);
    always_ff @(posedge hclk) begin
        cnt <= !energy ? 0 : (cnt > LINK_DLY + 2) ? cnt : cnt + 1;
    end
    assign link_up         = cnt >= LINK_DLY;
    assign partner_valid   = cnt >= LINK_DLY + 2;
    // A page that is not valid alternates while the count rises, so early reads see noise
    assign partner_ability = partner_valid ? ability : (cnt[0] ? 4'b1010 : 4'b0101);
endmodule : ppm_link_partner

// ### tb.sv
`timescale 1ns/1ps
module tb
    import ppm_pkg::*;
();
    // ==========================================================
    // Signals
    logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, remote_fault = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = '0, hwdata = '0, rd, hrdata;
    logic        hw_reset_pin_active_low = 1'b1, config_source_select_pin = 1'b1;
    logic        negotiation_select_pin = 1'b0, speed_select_pin = 1'b0;
    logic        duplex_select_pin = 1'b0, crossover_enable_pin = 1'b1, xs;
    logic        rx_activity = 1'b0, tx_activity = 1'b0, tx_pos_data = 1'b1;
    logic        tx_neg_data = 1'b0, plugged = 1'b1, crossed = 1'b0;
    logic [3:0]  noise_level = 4'h0, ability = 4'b1000, partner_ability;
    ppm_rx_t     rx_in = '0, rx_out;
    ppm_mode_t   op_mode;
    logic        hreadyout, hresp, link_up, partner_valid, crs, col, pair_swap;
    logic        pair_tx_positive, pair_tx_positive_oe_n, pair_tx_negative;
    logic        pair_tx_negative_oe_n, pcs100_enable, pcs10_enable;
    logic        loopback_enable, sqe_test_enable;
    int          n_fail = 0, samples_checked = 0;
    logic [3:0]  abl [4] = '{4'b1000, 4'b0110, 4'b0011, 4'b0001};
    ppm_mode_t   exm [4] = '{2'b11, 2'b10, 2'b01, 2'b00};

    ppm_phy_mode_ctrl #(.XO_WAIT_CYCLES(8)) dut (
        .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .hw_reset_pin_active_low,
        .config_source_select_pin, .negotiation_select_pin, .speed_select_pin,
        .duplex_select_pin, .crossover_enable_pin, .link_up, .partner_valid,
        .partner_ability, .remote_fault, .noise_level, .rx_activity, .tx_activity,
        .rx_in, .tx_pos_data, .tx_neg_data, .rx_out, .crs, .col, .pair_tx_positive,
        .pair_tx_positive_oe_n, .pair_tx_negative, .pair_tx_negative_oe_n, .pair_swap,
        .pcs100_enable, .pcs10_enable, .loopback_enable, .sqe_test_enable, .op_mode
    );
    ppm_link_partner partner (
        .hclk, .plugged, .crossed, .tx_oe_n(pair_tx_positive_oe_n), .swap(pair_swap),
        .ability, .link_up, .partner_valid, .partner_ability
    );

    // ==========================================================
    // Tasks
    task automatic complete_run;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wait_rdy;
        repeat (50) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        n_fail++;
        complete_run();
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        htrans <= 2'b10;
        haddr  <= {22'h00_0000, idx, 2'b00};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb

    task automatic rdm(input string what, input logic [7:0] idx,
                       input logic [31:0] m, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0000_0000);
        chk(what, exp, rd & m);
    endtask : rdm

    task automatic wait_mode(input ppm_mode_t exp);
        repeat (300) begin
            @(posedge hclk);
            if (op_mode === exp) break;
        end
        chk("op_mode", 32'(exp), 32'(op_mode));
        if (op_mode !== exp) complete_run();
        repeat (2) @(posedge hclk);
    endtask : wait_mode

    task automatic replug(input logic [3:0] ab, input logic xo);
        plugged <= 1'b0;
        ability <= ab;
        crossed <= xo;
        repeat (4) @(posedge hclk);
        plugged <= 1'b1;
    endtask : replug

    // ==========================================================
    // Sequence
    initial begin
        forever #2 hclk = ~hclk;
    end

    initial begin
        repeat (100000) @(posedge hclk);
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdm("ctrl", CTRL_IDX, 32'hFFFF_FFFF, 32'(CTRL_RST));
        rdm("ext2", EXT2_IDX, 32'hFFFF_FFFF, 32'(EXT2_RST));
        rdm("unmapped", 8'h3F, 32'hFFFF_FFFF, 32'h0000_0000);
        foreach (abl[i]) begin
            replug(abl[i], 1'b0);
            wait_mode(exm[i]);
        end
        for (int m = 0; m < 4; m++) begin
            ahb(1'b1, CTRL_IDX, {16'h0000, 2'b00, m[1], 4'h0, m[0], 8'h00});
            ahb(1'b1, EXT2_IDX, 32'h0000_0003);
            wait_mode(ppm_mode_t'(m[1:0]));
            chk("pcs100", 32'(m[1]), 32'(pcs100_enable));
            chk("pcs10", 32'(!m[1]), 32'(pcs10_enable));
            ahb(1'b1, EXT2_IDX, 32'h0000_0000);
            repeat (2) @(posedge hclk);
            chk("pcs_on", 32'h0000_0003, 32'({pcs100_enable, pcs10_enable}));
            tx_activity <= 1'b1;
            repeat (2) @(posedge hclk);
            chk("crs_tx", 32'(!m[0]), 32'(crs));
            rx_activity <= 1'b1;
            repeat (2) @(posedge hclk);
            chk("crs_col", 32'({1'b1, !m[0]}), 32'({crs, col}));
            if (m == 1) begin
                chk("lpbk_sqe", 32'h0000_0000, 32'({loopback_enable, sqe_test_enable}));
            end
            tx_activity <= 1'b0;
            rx_activity <= 1'b0;
        end
        config_source_select_pin <= 1'b0;
        duplex_select_pin        <= 1'b1;
        wait_mode(2'b01);
        ability                <= 4'b0100;
        negotiation_select_pin <= 1'b1;
        wait_mode(2'b10);
        config_source_select_pin <= 1'b1;
        wait_mode(2'b11);
        ahb(1'b1, CTRL_IDX, 32'h0000_1000);
        replug(4'b0011, 1'b1);
        wait_mode(2'b01);
        chk("swap", 32'h0000_0001, 32'(pair_swap));
        rdm("mdix", MODE_IDX, 32'h0000_0004, 32'h0000_0004);
        crossover_enable_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        xs = pair_swap;
        replug(4'b0001, !xs);
        repeat (3) begin
            repeat (12) @(posedge hclk);
            chk("swap_held", 32'(xs), 32'(pair_swap));
        end
        crossover_enable_pin <= 1'b1;
        for (int k = 1; k < 4; k++) begin
            ahb(1'b1, EXT2_IDX, 32'(k) << 8);
            repeat (4) @(posedge hclk);
            chk("swap_force", 32'(k == 2), 32'(pair_swap));
        end
        ahb(1'b1, EXT2_IDX, 32'h0000_0000);
        replug(4'b1000, 1'b1);
        wait_mode(2'b11);
        remote_fault <= 1'b1;
        noise_level  <= 4'h6;
        @(posedge hclk);
        remote_fault <= 1'b0;
        ahb(1'b1, EXT2_IDX, 32'h0000_0003);
        ahb(1'b1, CTRL_IDX, 32'h0000_1900);
        rx_activity <= 1'b1;
        tx_activity <= 1'b1;
        rx_in       <= 6'h2B;
        ability     <= 4'b0011;
        repeat (3) @(posedge hclk);
        chk("oe_pd", 32'h0000_0003,
            32'({pair_tx_positive_oe_n, pair_tx_negative_oe_n}));
        chk("host_pd", 32'h0000_0000, 32'({crs, col, rx_out, pair_tx_positive,
            pcs100_enable, pcs10_enable}));
        rdm("ctrl_pd", CTRL_IDX, 32'hFFFF_FFFF, 32'h0000_1900);
        rdm("ext2_pd", EXT2_IDX, 32'hFFFF_FFFF, 32'h0000_0003);
        rdm("latch_pd", STAT_IDX, 32'h0000_0F14, 32'h0000_0000);
        rdm("pd_bit", MODE_IDX, 32'h0000_0040, 32'h0000_0040);
        ahb(1'b1, CTRL_IDX, 32'h0000_1100);
        wait_mode(2'b01);
        chk("oe_up", 32'h0000_0000,
            32'({pair_tx_positive_oe_n, pair_tx_negative_oe_n}));
        chk("rx_out", 32'h0000_002B, 32'(rx_out));
        chk("crs_fd", 32'h0000_0002, 32'({crs, col}));
        chk("tx_line", 32'h0000_0002, 32'({pair_tx_positive, pair_tx_negative}));
        ahb(1'b1, EXT2_IDX, 32'h0000_0201);
        hw_reset_pin_active_low <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("oe_rst", 32'h0000_0007,
            32'({pair_tx_positive_oe_n, pair_tx_negative_oe_n, !crs}));
        rdm("pd_rst", MODE_IDX, 32'h0000_0040, 32'h0000_0040);
        hw_reset_pin_active_low <= 1'b1;
        repeat (2) @(posedge hclk);
        rdm("ctrl_rst", CTRL_IDX, 32'hFFFF_FFFF, 32'(CTRL_RST));
        rdm("ext2_rst", EXT2_IDX, 32'hFFFF_FFFF, 32'(EXT2_RST));
        complete_run();
    end
endmodule : tb
